/* core/pswc_consts.svh */
// constants of the power-state and wake controller
// Behaviour
// - one normal state, two sleeps, config kept
// - sleep entry clears ready until normal again
// - writes ignored until first read after reset/wake
// - byte-test write in sleep wakes, mode normal
// - mode 01 enters light sleep, PHY clocked
// - light sleep keeps receive power logic clocked
// - light sleep detects wake frames, source 10b
// - light wake drives pin if both enabled
// - event status set whatever pin enable says
// - deep sleep stops MAC and host clocks
// - deep carrier sets source 01b, even at entry
// - event status held while event; W1C after
// - pulse select gives 50ms pulse, else level
// - pin drops on source or enable clear
// - general powerdown holds PHY, clearing resets it
// - energy powerdown without energy silences PHY
// - energy arrival in energy powerdown sets flag, optional interrupt
// - ready within 2ms after wake write
`ifndef PSWC_CONSTS_SVH
`define PSWC_CONSTS_SVH

// ==============================
// register offsets (byte addresses)
`define PSWC_ADDR_PWR_CTRL  8'h00
`define PSWC_ADDR_BYTE_TEST 8'h04
`define PSWC_ADDR_INTERRUPT_STATUS_REG   8'h08
`define PSWC_ADDR_INT_EN    8'h0C
`define PSWC_ADDR_PHY_CTRL  8'h10
`define PSWC_ADDR_PHY_STAT  8'h14

// ==============================
// power_control_reg fields
`define PSWC_PC_READY     0
`define PSWC_PC_PIN_EN    1
`define PSWC_PC_PULSE_SEL 2
`define PSWC_PC_WF_EN     3
`define PSWC_PC_ENERGY_DETECT_ENABLE     4
`define PSWC_PC_WAKE_SOURCE_STATUS_LO   6
`define PSWC_PC_WAKE_SOURCE_STATUS_HI   7
`define PSWC_PC_MODE_LO   12
`define PSWC_PC_MODE_HI   13

// phy control / status fields
`define PSWC_PHC_GEN_PD   0
`define PSWC_PHC_ED_PD    1
`define PSWC_PHC_IRQ_EN   2
`define PSWC_PHS_FLAG     0
`define PSWC_PHS_ENERGY   1
`define PSWC_PHS_POWERED  2

// ==============================
// encodings and reset values
`define PSWC_MODE_NORMAL  2'h0
`define PSWC_MODE_LIGHT   2'h1
`define PSWC_MODE_DEEP    2'h2
`define PSWC_WAKE_SOURCE_STATUS_FRAME   2'h2
`define PSWC_WAKE_SOURCE_STATUS_ENERGY  2'h1
// byte-test pattern value is arbitrary
`define PSWC_BYTE_TEST_VAL 32'hA5C3_5A3C

// ==============================
// timing
`define PSWC_CLK_KHZ        50000
`define PSWC_PME_PULSE_MS   50
`define PSWC_PME_PULSE_CYC  (`PSWC_PME_PULSE_MS * `PSWC_CLK_KHZ)
`define PSWC_WAKE_MAX_MS    2
`define PSWC_WAKE_MAX_CYC   (`PSWC_WAKE_MAX_MS * `PSWC_CLK_KHZ)
`define PSWC_WAKE_SETTLE_CYC 64

`endif

/* core/pswc_event_pin.sv */
// external wake event pin, pulsed or static
`timescale 1ns/1ps
module pswc_event_pin #(
  parameter int unsigned PULSE_CYC = 2500000,
  parameter int unsigned CW        = 22
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic evt,
  input  wire logic pinEn,
  input  wire logic pulseSel,
  output logic      pinOut
);

  logic          trigPrev_q;
  logic [CW-1:0] cnt_q;
  logic          trig;

  assign trig = evt & pinEn;

  generate
    if (PULSE_CYC < 1 || PULSE_CYC >= (64'd1 << CW)) begin : g_chk
      $error("pswc_event_pin: pulse count does not fit counter");
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= trig;
    end
  end

  // ==============================
  // pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= 1'b0;
      cnt_q  <= '0;
    // drop on cleared source or enable
    end else if (!trig) begin
      pinOut <= 1'b0;
      cnt_q  <= '0;
    end else if (!pulseSel) begin
      pinOut <= 1'b1;
      cnt_q  <= '0;
    end else if (!trigPrev_q) begin
      pinOut <= 1'b1;
      cnt_q  <= CW'(PULSE_CYC - 1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end else begin
      pinOut <= 1'b0;
    end
  end

endmodule

/* core/pswc_phy_if.sv */
// control and status carried between the controller and the PHY power model
`timescale 1ns/1ps
interface pswc_phy_if;
  logic genPd;
  logic edPd;
  logic irqEn;
  logic flagClr;
  logic energy;
  logic powered;
  logic txEnable;
  logic autoReset;
  logic energyFlag;
  logic irq;

  modport ctrl (output genPd, output edPd, output irqEn, output flagClr, output energy,
                input powered, input txEnable, input autoReset, input energyFlag, input irq);
  modport phy  (input genPd, input edPd, input irqEn, input flagClr, input energy,
                output powered, output txEnable, output autoReset, output energyFlag,
                output irq);
endinterface

/* core/pswc_phy_power.sv */
// PHY general and energy-detect power-down control
`timescale 1ns/1ps
module pswc_phy_power import pswc_pkg::*; (
  input  wire logic clk,
  input  wire logic rst,
  pswc_phy_if.phy   p
);

  logic genPdPrev_q;
  logic energyPrev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      genPdPrev_q  <= 1'b0;
      energyPrev_q <= 1'b0;
    end else begin
      genPdPrev_q  <= p.genPd;
      energyPrev_q <= p.energy;
    end
  end

  // ==============================
  // power and transmit state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p.powered   <= 1'b1;
      p.txEnable  <= 1'b1;
      p.autoReset <= 1'b0;
    end else begin
      // general powerdown, or energy powerdown with no energy, means off and silent
      p.powered   <= ~p.genPd & ~(p.edPd & ~p.energy);
      p.txEnable  <= ~p.genPd & ~(p.edPd & ~p.energy);
      p.autoReset <= genPdPrev_q & ~p.genPd;
    end
  end

  // ==============================
  // energy arrival flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p.energyFlag <= 1'b0;
      p.irq        <= 1'b0;
    end else begin
      // energy rise in energy powerdown sets flag, gated irq
      p.energyFlag <= pswc_sticky(p.energyFlag, p.edPd & p.energy & ~energyPrev_q, p.flagClr);
      p.irq        <= p.energyFlag & p.irqEn;
    end
  end

endmodule

/* core/pswc_pkg.sv */
// types and helpers of the power-state and wake controller
package pswc_pkg;

  typedef enum logic [3:0] {
    PSWC_NORMAL = 4'h1,
    PSWC_LIGHT  = 4'h2,
    PSWC_DEEP   = 4'h4,
    PSWC_WAKING = 4'h8
  } pswc_state_t;

  // sticky flag: a set in the clearing cycle wins
  function automatic logic pswc_sticky(input logic q, input logic set, input logic clr);
    return set | (q & ~clr);
  endfunction

endpackage

/* core/pswc_top.sv */
// power-state and wake controller with AHB-Lite register slave
`timescale 1ns/1ps
`include "pswc_consts.svh"
module pswc_top import pswc_pkg::*; #(
  parameter int unsigned PME_PULSE_CYC   = `PSWC_PME_PULSE_CYC,
  parameter int unsigned WAKE_SETTLE_CYC = `PSWC_WAKE_SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        wakeFrameDet,
  input  wire logic        remoteWakeDet,
  input  wire logic        lineEnergyPin,
  output logic             eventPinOut,
  output logic             eventIrq,
  output logic             hostClkEn,
  output logic             macClkEn,
  output logic             macRxPmClkEn,
  output logic             phyClkEn,
  output logic             phyPowered,
  output logic             phyTxEnable,
  output logic             phyAutoReset,
  output logic             phyIrq
);

  localparam int unsigned SW = 17;

  generate
    // settle must stay inside wake limit
    if (WAKE_SETTLE_CYC < 1 || WAKE_SETTLE_CYC > `PSWC_WAKE_MAX_CYC) begin : g_chk
      $error("pswc_top: wake settle count out of range");
    end
  endgenerate

  // ==============================
  // declarations
  pswc_state_t   state_q;
  pswc_state_t   state_d;
  logic [SW-1:0] settle_q;
  logic          ready_q;
  logic          readSeen_q;
  logic          wrPend_q;
  logic [7:0]    wrAddr_q;
  logic          pinEn_q;
  logic          pulseSel_q;
  logic          wfEn_q;
  logic          edEn_q;
  logic [1:0]    wake_source_status_q;
  logic          intSts_q;
  logic          intEn_q;
  logic          genPd_q;
  logic          edPd_q;
  logic          phyIrqEn_q;
  logic          energyMeta_q;
  logic          energySync_q;
  logic          addrPh;
  logic          wrOk;
  logic          pwrWr;
  logic          wakeWr;
  logic          sleeping;
  logic          pmeInt;
  logic [1:0]    pmMode;
  logic [1:0]    modeWr;
  logic [31:0]   rdVal;

  pswc_phy_if phyIf ();

  // ==============================
  // line energy synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      energyMeta_q <= 1'b0;
      energySync_q <= 1'b0;
    end else begin
      energyMeta_q <= lineEnergyPin;
      energySync_q <= energyMeta_q;
    end
  end

  // ==============================
  // bus decode
  assign addrPh   = hsel & htrans[1] & hready;
  assign sleeping = (state_q == PSWC_LIGHT) || (state_q == PSWC_DEEP);
  assign wrOk     = wrPend_q & readSeen_q & ready_q;
  assign pwrWr    = wrOk & (wrAddr_q == `PSWC_ADDR_PWR_CTRL);
  assign wakeWr   = wrPend_q & sleeping & (wrAddr_q == `PSWC_ADDR_BYTE_TEST);
  assign modeWr   = hwdata[`PSWC_PC_MODE_HI:`PSWC_PC_MODE_LO];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= addrPh & hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==============================
  // first-read tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readSeen_q <= 1'b0;
    // a read rearms writes, set wins
    end else if (addrPh & ~hwrite) begin
      readSeen_q <= 1'b1;
    end else if (wakeWr) begin
      readSeen_q <= 1'b0;
    end
  end

  // ==============================
  // power state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSWC_NORMAL: begin
        if (pwrWr && modeWr == `PSWC_MODE_LIGHT) begin
          state_d = PSWC_LIGHT;
        // deep entry after host prepares PHY
        end else if (pwrWr && modeWr == `PSWC_MODE_DEEP) begin
          state_d = PSWC_DEEP;
        end
      end
      PSWC_LIGHT, PSWC_DEEP: begin
        if (wakeWr) begin
          state_d = PSWC_WAKING;
        end
      end
      PSWC_WAKING: begin
        if (settle_q == SW'(WAKE_SETTLE_CYC - 1)) begin
          state_d = PSWC_NORMAL;
        end
      end
      default: begin
        state_d = PSWC_WAKING;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PSWC_WAKING;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_q <= '0;
    end else if (state_q != PSWC_WAKING) begin
      settle_q <= '0;
    end else begin
      settle_q <= settle_q + SW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_d == PSWC_NORMAL);
    end
  end

  always_comb begin
    case (state_q)
      PSWC_LIGHT: pmMode = `PSWC_MODE_LIGHT;
      PSWC_DEEP:  pmMode = `PSWC_MODE_DEEP;
      default:    pmMode = `PSWC_MODE_NORMAL;
    endcase
  end

  // ==============================
  // clock gating per state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostClkEn    <= 1'b1;
      macClkEn     <= 1'b1;
      macRxPmClkEn <= 1'b1;
      phyClkEn     <= 1'b1;
    end else begin
      // light sleep gates host and MAC
      // deep sleep stops MAC and host
      hostClkEn    <= (state_d == PSWC_NORMAL) || (state_d == PSWC_WAKING);
      macClkEn     <= (state_d == PSWC_NORMAL) || (state_d == PSWC_WAKING);
      macRxPmClkEn <= (state_d != PSWC_DEEP);
      // PHY clock stays on in light sleep
      phyClkEn     <= (state_d != PSWC_DEEP);
    end
  end

  // ==============================
  // configuration registers, kept through sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinEn_q    <= 1'b0;
      pulseSel_q <= 1'b0;
      wfEn_q     <= 1'b0;
      edEn_q     <= 1'b0;
    end else if (pwrWr) begin
      pinEn_q    <= hwdata[`PSWC_PC_PIN_EN];
      pulseSel_q <= hwdata[`PSWC_PC_PULSE_SEL];
      wfEn_q     <= hwdata[`PSWC_PC_WF_EN];
      edEn_q     <= hwdata[`PSWC_PC_ENERGY_DETECT_ENABLE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intEn_q    <= 1'b0;
      genPd_q    <= 1'b0;
      edPd_q     <= 1'b0;
      phyIrqEn_q <= 1'b0;
    end else if (wrOk && wrAddr_q == `PSWC_ADDR_INT_EN) begin
      intEn_q <= hwdata[0];
    end else if (wrOk && wrAddr_q == `PSWC_ADDR_PHY_CTRL) begin
      genPd_q    <= hwdata[`PSWC_PHC_GEN_PD];
      edPd_q     <= hwdata[`PSWC_PHC_ED_PD];
      phyIrqEn_q <= hwdata[`PSWC_PHC_IRQ_EN];
    end
  end

  // ==============================
  // wake detection and event status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_source_status_q <= 2'h0;
    end else begin
      wake_source_status_q[1] <= pswc_sticky(wake_source_status_q[1],
                               (state_q == PSWC_LIGHT) & (wakeFrameDet | remoteWakeDet),
                               pwrWr & hwdata[`PSWC_PC_WAKE_SOURCE_STATUS_HI]);
      wake_source_status_q[0] <= pswc_sticky(wake_source_status_q[0], (state_q == PSWC_DEEP) & energySync_q,
                               pwrWr & hwdata[`PSWC_PC_WAKE_SOURCE_STATUS_LO]);
    end
  end

  // event drops with source or enable
  assign pmeInt = (wake_source_status_q[1] & wfEn_q) | (wake_source_status_q[0] & edEn_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intSts_q <= 1'b0;
      eventIrq <= 1'b0;
    end else begin
      // clear only bites once event gone
      intSts_q <= pswc_sticky(intSts_q, pmeInt,
                              wrOk & (wrAddr_q == `PSWC_ADDR_INTERRUPT_STATUS_REG) & hwdata[0]);
      eventIrq <= intSts_q & intEn_q;
    end
  end

  // ==============================
  // event pin
  // pin needs source enable and pin enable
  pswc_event_pin #(
    .PULSE_CYC (PME_PULSE_CYC),
    .CW        (22)
  ) u_pin (
    .clk      (clk),
    .rst      (rst),
    .evt      (pmeInt),
    .pinEn    (pinEn_q),
    .pulseSel (pulseSel_q),
    .pinOut   (eventPinOut)
  );

  // ==============================
  // PHY power model
  assign phyIf.genPd   = genPd_q;
  assign phyIf.edPd    = edPd_q;
  assign phyIf.irqEn   = phyIrqEn_q;
  assign phyIf.energy  = energySync_q;
  assign phyIf.flagClr = wrOk & (wrAddr_q == `PSWC_ADDR_PHY_STAT) & hwdata[`PSWC_PHS_FLAG];
  assign phyPowered    = phyIf.powered;
  assign phyTxEnable   = phyIf.txEnable;
  assign phyAutoReset  = phyIf.autoReset;
  assign phyIrq        = phyIf.irq;

  pswc_phy_power u_phy (
    .clk (clk),
    .rst (rst),
    .p   (phyIf.phy)
  );

  // ==============================
  // read data
  always_comb begin
    rdVal = 32'h0000_0000;
    case (haddr[7:0])
      `PSWC_ADDR_PWR_CTRL: begin
        rdVal[`PSWC_PC_READY]                     = ready_q;
        rdVal[`PSWC_PC_PIN_EN]                    = pinEn_q;
        rdVal[`PSWC_PC_PULSE_SEL]                 = pulseSel_q;
        rdVal[`PSWC_PC_WF_EN]                     = wfEn_q;
        rdVal[`PSWC_PC_ENERGY_DETECT_ENABLE]                     = edEn_q;
        rdVal[`PSWC_PC_WAKE_SOURCE_STATUS_HI:`PSWC_PC_WAKE_SOURCE_STATUS_LO]  = wake_source_status_q;
        rdVal[`PSWC_PC_MODE_HI:`PSWC_PC_MODE_LO]  = pmMode;
      end
      `PSWC_ADDR_BYTE_TEST: rdVal = `PSWC_BYTE_TEST_VAL;
      `PSWC_ADDR_INTERRUPT_STATUS_REG:   rdVal[0] = intSts_q;
      `PSWC_ADDR_INT_EN:    rdVal[0] = intEn_q;
      `PSWC_ADDR_PHY_CTRL: begin
        rdVal[`PSWC_PHC_GEN_PD] = genPd_q;
        rdVal[`PSWC_PHC_ED_PD]  = edPd_q;
        rdVal[`PSWC_PHC_IRQ_EN] = phyIrqEn_q;
      end
      `PSWC_ADDR_PHY_STAT: begin
        rdVal[`PSWC_PHS_FLAG]    = phyIf.energyFlag;
        rdVal[`PSWC_PHS_ENERGY]  = energySync_q;
        rdVal[`PSWC_PHS_POWERED] = phyIf.powered;
      end
      default: rdVal = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPh & ~hwrite) begin
      if (!ready_q && haddr[7:0] != `PSWC_ADDR_PWR_CTRL) begin
        hrdata <= 32'h0000_0000;
      end else begin
        hrdata <= rdVal;
      end
    end
  end

endmodule

/* test/pswc_asserts.sv */
// concurrent checks on the ports of the power-state and wake controller
`timescale 1ns/1ps
module pswc_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        hostClkEn,
  input wire logic        macClkEn,
  input wire logic        macRxPmClkEn,
  input wire logic        phyClkEn,
  input wire logic        phyPowered,
  input wire logic        phyTxEnable,
  input wire logic        phyAutoReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==============================
  // bus phases
  sequence addrPh; hsel && htrans[1] && hready; endsequence
  sequence rdPh; addrPh ##0 !hwrite; endsequence
  sequence wakeWr; addrPh ##0 hwrite && haddr[7:0] == 8'h04; endsequence
  // host clock off marks a sleep state at the pins, as MAC clock off does
  sequence asleep; !hostClkEn; endsequence
  // ==============================
  // assertions
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  chk_deep_clocks: assert property (
    !phyClkEn |-> !hostClkEn && !macClkEn && !macRxPmClkEn)
    else $error("clock running in deep sleep");
  chk_light_clocks: assert property (
    !hostClkEn && phyClkEn |-> macRxPmClkEn && !macClkEn)
    else $error("light sleep clock gating wrong");
  chk_tx_follows: assert property (phyTxEnable == phyPowered)
    else $error("PHY transmits while powered down");
  chk_reset_pulse: assert property (phyAutoReset |=> !phyAutoReset)
    else $error("PHY auto reset longer than one cycle");
  chk_sleep_ready: assert property (
    rdPh ##0 haddr[7:0] == 8'h00 ##0 asleep |=> hrdata[0] == 1'b0)
    else $error("ready seen in sleep");
  chk_sleep_rd_zero: assert property (
    rdPh ##0 haddr[7:0] != 8'h00 ##0 asleep |=> hrdata == 32'h0000_0000)
    else $error("sleep read of other register not zero");
  chk_wake_clocks: assert property (
    wakeWr ##0 asleep |=> ##1 hostClkEn && macClkEn && phyClkEn)
    else $error("wake write did not restart clocks");
endmodule

bind pswc_top pswc_asserts u_chk (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hresp(hresp), .hostClkEn(hostClkEn),
  .macClkEn(macClkEn), .macRxPmClkEn(macRxPmClkEn), .phyClkEn(phyClkEn),
  .phyPowered(phyPowered), .phyTxEnable(phyTxEnable), .phyAutoReset(phyAutoReset)
);

/* test/pswc_host_model.sv */
// host processor model: single-word AHB-Lite master
`timescale 1ns/1ps
module pswc_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // ==============================
  // one transfer, entered just after a rising edge; tmo flags a silent slave
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic tmo);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    haddr  <= ~{24'h00_0000, a};
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd  = hrdata;
    tmo = (n >= 100);
    // released data lines must not keep looking valid
    hwdata <= ~wd;
  endtask
endmodule

/* test/tb.sv */
// self-checking bench of the power-state and wake controller
`timescale 1ns/1ps
module tb;
  localparam int SETTLE = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wakeFrameDet = 1'b0;
  logic        remoteWakeDet = 1'b0;
  logic        lineEnergy = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, eventPinOut, eventIrq;
  logic        hostClkEn, macClkEn, macRxPmClkEn, phyClkEn;
  logic        phyPowered, phyTxEnable, phyAutoReset, phyIrq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          errors = 0;
  int          totalChecks = 0;
  int          cyc = 0;

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  pswc_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // short pulse and settle counts keep the run brief
  pswc_top #(.PME_PULSE_CYC(20), .WAKE_SETTLE_CYC(SETTLE)) uut (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wakeFrameDet(wakeFrameDet), .remoteWakeDet(remoteWakeDet),
    .lineEnergyPin(lineEnergy), .eventPinOut(eventPinOut), .eventIrq(eventIrq),
    .hostClkEn(hostClkEn), .macClkEn(macClkEn), .macRxPmClkEn(macRxPmClkEn),
    .phyClkEn(phyClkEn), .phyPowered(phyPowered), .phyTxEnable(phyTxEnable),
    .phyAutoReset(phyAutoReset), .phyIrq(phyIrq));

  // ==============================
  // shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic tmo;
    host.xfer(w, a, wd, rd, tmo);
    if (tmo) begin
      errors++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(n, e & m, x & m);
  endtask
  // polls ready after a wake write issued at cycle t0
  task automatic waitReady(input int t0);
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h00, 32'h0, x);
      n++;
    end while (x[0] !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      summarize();
    end
    chk("wake settle", 1, cyc - t0 >= SETTLE && cyc - t0 <= SETTLE + 6);
  endtask

  // ==============================
  // scenarios
  task automatic t_reset();
    repeat (SETTLE + 4) @(posedge clk);
    wr(8'h00, 32'h0000_001A);
    rdc("pc before read", 8'h00, 32'h0000_0001, 32'hFFFF);
    wr(8'h00, 32'h0000_001A);
    rdc("pc after read", 8'h00, 32'h0000_001B, 32'hFFFF);
    rdc("byte test", 8'h04, 32'hA5C3_5A3C, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h20, 32'h0, 32'hFFFF_FFFF);
    wr(8'h0C, 32'h1);
    $display("reset test done");
  endtask

  task automatic t_phy();
    int n;
    wr(8'h10, 32'h1);
    // the PHY model registers the request one edge after the write lands
    repeat (2) @(posedge clk);
    chk("general pd", 0, {phyPowered, phyTxEnable});
    wr(8'h10, 32'h6);
    n = 0;
    while (phyAutoReset !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk("auto reset", 1, n < 8);
    repeat (2) @(posedge clk);
    chk("energy pd idle", 0, {phyPowered, phyTxEnable});
    lineEnergy <= 1'b1;
    repeat (6) @(posedge clk);
    chk("energy on", 3'b111, {phyPowered, phyTxEnable, phyIrq});
    rdc("phy flag", 8'h14, 32'h7, 32'h7);
    wr(8'h14, 32'h1);
    rdc("phy flag clear", 8'h14, 32'h6, 32'h7);
    $display("phy test done");
  endtask

  // remote selects the detector; its pass also runs with the pin disabled
  task automatic t_light(input logic remote);
    logic [31:0] base;
    int t0;
    base = remote ? 32'h18 : 32'h1A;
    wr(8'h00, base | 32'h1000);
    @(posedge clk);
    chk("light clocks", 3'b011, {hostClkEn, phyClkEn, macRxPmClkEn});
    rdc("light ready", 8'h00, 32'h0, 32'h1);
    rdc("light other", 8'h04, 32'h0, 32'hFFFF_FFFF);
    if (remote) remoteWakeDet <= 1'b1;
    else wakeFrameDet <= 1'b1;
    @(posedge clk);
    wakeFrameDet  <= 1'b0;
    remoteWakeDet <= 1'b0;
    repeat (4) @(posedge clk);
    chk("light pin", !remote, eventPinOut);
    chk("light irq", 1, eventIrq);
    t0 = cyc;
    wr(8'h04, 32'h0);
    waitReady(t0);
    rdc("light source", 8'h00, base | 32'h81, 32'hFFFF);
    wr(8'h08, 32'h1);
    rdc("status held", 8'h08, 32'h1, 32'h1);
    wr(8'h00, base | 32'h80);
    repeat (2) @(posedge clk);
    chk("pin dropped", 0, eventPinOut);
    wr(8'h08, 32'h1);
    rdc("status cleared", 8'h08, 32'h0, 32'h1);
    $display("light test done");
  endtask

  task automatic t_deep();
    int n;
    int t0;
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h0000_201E);
    @(posedge clk);
    chk("deep clocks", 0, {hostClkEn, macClkEn, phyClkEn, macRxPmClkEn});
    n = 0;
    while (eventPinOut !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("carrier at entry", 1, n < 20);
    n = 0;
    while (eventPinOut === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("pulse length", 20, n);
    t0 = cyc;
    wr(8'h04, 32'h0);
    waitReady(t0);
    rdc("deep source", 8'h00, 32'h5F, 32'hFFFF);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h5E);
    wr(8'h08, 32'h1);
    rdc("deep status", 8'h08, 32'h0, 32'h1);
    $display("deep test done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_phy();
    t_light(1'b0);
    t_light(1'b1);
    t_deep();
    summarize();
  end
endmodule
